// >>> hdl/ckw_cmp.sv
`timescale 1ns/100ps
// Weight classifier against limits and checkweighing range.
module ckw_cmp
    import ckw_pkg::*;
#(
    parameter int W = CKW_W
)(
    input  wire logic         range_sel,
    input  wire logic [W-1:0] net,
    input  wire logic [W-1:0] target,
    input  wire logic [W-1:0] lower,
    input  wire logic [W-1:0] upper,
    output logic              below,
    output logic              above,
    output logic              in_rng,
    output logic              near
);
    localparam int PW = W + 5;
    logic [PW-1:0] n10;   // Net in tenths of a unit.
    logic [PW-1:0] t_lo;  // Bottom of the range.
    logic [PW-1:0] t_hi;  // Top of the range.
    logic [W-1:0]  half;  // Half the lower deviation.

    assign n10  = PW'(net) * PW'(RNG_DEN);
    assign t_lo = PW'(target) * PW'(range_sel ? RNG_LO_B : RNG_LO_A);
    assign t_hi = PW'(target) * PW'(RNG_HI_A);
    assign half = (target - lower) >> 1;

    // The open range has no upper bound.
    assign in_rng = (n10 >= t_lo) && (range_sel || n10 <= t_hi);
    assign below  = net < lower;
    assign above  = net > upper;
    // Set point trips when the load comes within half the lower deviation.
    assign near   = (PW'(net) + PW'(half)) >= PW'(target);
endmodule

// >>> hdl/ckw_pkg.sv
package ckw_pkg;
    // Weight word width in scale intervals (one digit is one LSB).
    localparam int CKW_W = 24;

    // Register byte offsets on the APB bus.
    localparam logic [7:0] ADR_CFG    = 8'h00;
    localparam logic [7:0] ADR_TARGET = 8'h04;
    localparam logic [7:0] ADR_LOWER  = 8'h08;
    localparam logic [7:0] ADR_UPPER  = 8'h0c;
    localparam logic [7:0] ADR_PCT    = 8'h10;
    localparam logic [7:0] ADR_CMD    = 8'h14;
    localparam logic [7:0] ADR_TARE   = 8'h18;
    localparam logic [7:0] ADR_STATUS = 8'h1c;
    localparam logic [7:0] ADR_NET    = 8'h20;
    localparam logic [7:0] ADR_BAR    = 8'h24;
    localparam logic [7:0] ADR_BAND   = 8'h28;

    // Configuration field positions.
    localparam int CFG_RANGE = 0;
    localparam int CFG_SET   = 1;
    localparam int CFG_GATE  = 2;
    localparam int CFG_ENTRY = 5;
    localparam int CFG_PRINT = 7;
    localparam int CFG_MINLD = 9;
    localparam int CFG_TAREM = 13;
    localparam int CFG_CLRSC = 14;
    localparam int CFG_DISP  = 15;
    localparam int CFG_ATARE = 16;
    localparam int CFG_BITS  = 17;
    localparam logic [16:0] CFG_RST = 17'h00028;

    // Command bits, each a one-shot action on write.
    localparam int CMD_CAP_TG = 0;
    localparam int CMD_CAP_LO = 1;
    localparam int CMD_CAP_HI = 2;
    localparam int CMD_REF    = 3;
    localparam int CMD_TARE   = 4;
    localparam int CMD_CLEAR  = 5;
    localparam int CMD_ACCEPT = 6;

    // Output gating settings, Gray ordered.
    typedef enum logic [2:0] {
        CKW_G_OFF = 3'h0, CKW_G_ALW = 3'h1, CKW_G_STB = 3'h3,
        CKW_G_RNG = 3'h2, CKW_G_SRG = 3'h6
    } ckw_gate_e;
    // Limit entry modes.
    typedef enum logic [1:0] {
        CKW_E_ABS = 2'h0, CKW_E_PPRE = 2'h1, CKW_E_PFREE = 2'h3, CKW_E_REL = 2'h2
    } ckw_entry_e;
    // Automatic print modes.
    typedef enum logic [1:0] {
        CKW_P_OFF = 2'h0, CKW_P_ON = 2'h1, CKW_P_IN = 2'h3, CKW_P_OUT = 2'h2
    } ckw_print_e;

    // Range window factors in tenths of the target.
    localparam logic [4:0] RNG_DEN  = 5'h0a;
    localparam logic [4:0] RNG_LO_A = 5'h03;
    localparam logic [4:0] RNG_HI_A = 5'h11;
    localparam logic [4:0] RNG_LO_B = 5'h01;
    // Percentages are held in tenths of a percent.
    localparam logic [9:0] PCT_DIV  = 10'h3e8;
    localparam logic [3:0] PCT_LAST = 4'h8;
    localparam logic [7:0] BAR_LO_MARK = 8'h20;

    // Preset deviation steps 0.1 .. 10 percent.
    function automatic logic [9:0] ckw_preset(input logic [3:0] idx);
        unique case (idx)
            4'h0: return 10'h001;
            4'h1: return 10'h002;
            4'h2: return 10'h005;
            4'h3: return 10'h00a;
            4'h4: return 10'h00f;
            4'h5: return 10'h014;
            4'h6: return 10'h01e;
            4'h7: return 10'h032;
            default: return 10'h064;
        endcase
    endfunction

    // Minimum load steps in scale intervals.
    function automatic logic [9:0] ckw_minload(input logic [3:0] idx);
        unique case (idx)
            4'h0: return 10'h001;
            4'h1: return 10'h002;
            4'h2: return 10'h005;
            4'h3: return 10'h00a;
            4'h4: return 10'h014;
            4'h5: return 10'h032;
            4'h6: return 10'h064;
            4'h7: return 10'h0c8;
            4'h8: return 10'h1f4;
            default: return 10'h3e8;
        endcase
    endfunction
endpackage

// >>> hdl/ckw_stab.sv
`timescale 1ns/100ps
// Stability detector: counts successive samples whose change stays in the band.
module ckw_stab
    import ckw_pkg::*;
#(
    parameter int W   = CKW_W,
    parameter int CNT = 4
)(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         sample,
    input  wire logic [W-1:0] weight,
    input  wire logic [W-1:0] band,
    output logic              stable
);
    localparam int CW = $clog2(CNT + 1);
    logic [W-1:0]  prev_q;   // Previous sample.
    logic [CW-1:0] cnt_q;    // Quiet samples seen in a row.
    logic [W-1:0]  diff;     // Absolute change between samples.

    assign diff = (weight >= prev_q) ? weight - prev_q : prev_q - weight;

    // A narrower band needs smaller changes, so stability is stricter.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prev_q <= '0;
            cnt_q  <= '0;
        end
        else if (sample)
        begin
            prev_q <= weight;
            if (diff > band)
                cnt_q <= '0;
            else if (cnt_q != CW'(CNT))
                cnt_q <= cnt_q + CW'(1);
        end
    end

    // Stable once enough quiet samples have been seen.
    assign stable = (cnt_q == CW'(CNT));
endmodule

// >>> hdl/ckw_top.sv
`timescale 1ns/100ps
// Function
// - Reject limits unless upper>=target>=lower>=1
// - Range 30..170 percent or 10 percent up
// - Reference key steps preset deviation percentages
// - Four limit entry modes, preset percent default
// - Five output gating settings, range default
// - Fourth output is set point or ready
// - Four outputs: lighter, equal, heavier, set
// - Outputs inactive uninitialised, unstable or out-of-range; last two per gating setting, ready output ungated
// - Outputs active low, idle high
// - Relative display shows below/above band indicators
// - Net weight always readable, even out-of-band
// - Bar log below lower, linear above
// - Autoprint off, on, inside or outside
// - Minimum load in ten interval steps
// - Autotare and autoprint need minimum load
// - Default tare mode adds manual to weighed
// - Alternate tare mode: newest tare replaces
// - Limits capturable from current platform weight
// - Clear key erases all or selected data
// - Setup data kept until cleared or overwritten
// - Stability means change within tolerance band
module ckw_top
    import ckw_pkg::*;
#(
    parameter int W        = CKW_W,
    parameter int STAB_CNT = 4
)(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    input  wire logic [W-1:0] weight_in,
    input  wire logic         weight_valid,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    output logic              lighter_n,
    output logic              equal_n,
    output logic              heavier_n,
    output logic              set_n,
    output logic              below_band_indicator,
    output logic              above_band_indicator,
    output logic              print_req
);
    // Bus and register state.
    logic [31:0]         prdata_q;   // Read data.
    logic                pready_q;   // Access-phase ready.
    logic                pslverr_q;  // Unmapped address flag.
    logic [CFG_BITS-1:0] cfg_q;      // Configuration word.
    logic [W-1:0]        tg_q;       // Entered target.
    logic [W-1:0]        lo_q;       // Entered lower value.
    logic [W-1:0]        hi_q;       // Entered upper value.
    logic [9:0]          pct_q;      // Free percent, tenths.
    logic [3:0]          pidx_q;     // Preset percent index.
    logic [W-1:0]        band_q;     // Stability band.
    logic [W-1:0]        tare_q;     // Stored tare.
    logic [W-1:0]        gross_q;    // Latest gross sample.
    logic [W-1:0]        act_tg_q;   // Accepted target.
    logic [W-1:0]        act_lo_q;   // Accepted lower limit.
    logic [W-1:0]        act_hi_q;   // Accepted upper limit.
    logic                init_q;     // Application initialised.
    logic                err_q;      // Last entry rejected.
    logic                armed_q;    // Autoprint may fire.
    logic [7:0]          bar_q;      // Bar position.
    // Output flip-flops.
    logic light_n_q, equal_n_q, heavy_n_q, set_n_q;
    logic bli_q, abi_q, print_q;

    // Decoded controls and combinational results.
    ckw_gate_e  gate;
    ckw_entry_e entry;
    ckw_print_e pmode;
    logic         wr_en, setup, stable, below, above, in_rng, near;
    logic         gate_en, acc_ok;
    logic [6:0]   cmd;
    logic [W-1:0] net, minld, eff_lo, eff_hi, dev, tare_nx;
    logic [9:0]   pval;
    logic [W+9:0] prod;
    logic [31:0]  rd_mux;
    logic         rd_hit;

    assign gate  = ckw_gate_e'(cfg_q[CFG_GATE +: 3]);
    assign entry = ckw_entry_e'(cfg_q[CFG_ENTRY +: 2]);
    assign pmode = ckw_print_e'(cfg_q[CFG_PRINT +: 2]);
    assign minld = W'(ckw_minload(cfg_q[CFG_MINLD +: 4]));
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready_q && pwrite;
    assign cmd   = (wr_en && paddr == ADR_CMD) ? pwdata[6:0] : 7'h00;

    // Net weight never goes below zero.
    assign net = (gross_q >= tare_q) ? gross_q - tare_q : '0;

    // Stability judged on each new sample.
    ckw_stab #(.W(W), .CNT(STAB_CNT)) u_stab (
        .pclk    (pclk),
        .presetn (presetn),
        .sample  (weight_valid),
        .weight  (weight_in),
        .band    (band_q),
        .stable  (stable)
    );

    // Classification against the accepted limits.
    ckw_cmp #(.W(W)) u_cmp (
        .range_sel (cfg_q[CFG_RANGE]),
        .net       (net),
        .target    (act_tg_q),
        .lower     (act_lo_q),
        .upper     (act_hi_q),
        .below     (below),
        .above     (above),
        .in_rng    (in_rng),
        .near      (near)
    );

    // Limits derived from the entry mode, then checked before acceptance.
    always_comb
    begin
        pval = (entry == CKW_E_PFREE) ? pct_q : ckw_preset(pidx_q);
        prod = (W + 10)'(tg_q) * (W + 10)'(pval);
        dev  = W'(prod / (W + 10)'(PCT_DIV));
        unique case (entry)
            CKW_E_ABS:
            begin
                eff_lo = lo_q;
                eff_hi = hi_q;
            end
            CKW_E_REL:
            begin
                eff_lo = (lo_q > tg_q) ? '0 : tg_q - lo_q;
                eff_hi = tg_q + hi_q;
            end
            default:
            begin
                eff_lo = (dev > tg_q) ? '0 : tg_q - dev;
                eff_hi = tg_q + dev;
            end
        endcase
        acc_ok = (eff_hi >= tg_q) && (tg_q >= eff_lo) && (eff_lo >= W'(1));
    end

    // Gating of the control lines.
    always_comb
    begin
        unique case (gate)
            CKW_G_OFF: gate_en = 1'b0;
            CKW_G_ALW: gate_en = 1'b1;
            CKW_G_STB: gate_en = stable;
            CKW_G_RNG: gate_en = in_rng;
            CKW_G_SRG: gate_en = stable && in_rng;
            default:   gate_en = 1'b0;
        endcase
        gate_en = gate_en && init_q;
    end

    // Read multiplexer; unmapped addresses read zero with an error.
    always_comb
    begin
        rd_hit = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            ADR_CFG:    rd_mux = 32'(cfg_q);
            ADR_TARGET: rd_mux = 32'(tg_q);
            ADR_LOWER:  rd_mux = 32'(lo_q);
            ADR_UPPER:  rd_mux = 32'(hi_q);
            ADR_PCT:    rd_mux = 32'({pidx_q, pct_q});
            ADR_CMD:    rd_mux = 32'h0000_0000;
            ADR_TARE:   rd_mux = 32'(tare_q);
            ADR_STATUS: rd_mux = 32'({abi_q, bli_q, above, !below && !above,
                                      below, in_rng, stable, err_q, init_q});
            ADR_NET:    rd_mux = 32'(net);
            ADR_BAR:    rd_mux = 32'(bar_q);
            ADR_BAND:   rd_mux = 32'(band_q);
            default:    rd_hit = 1'b0;
        endcase
    end

    // APB slave: data is latched in the setup cycle, ready in the access.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q  <= setup;
            pslverr_q <= setup && !rd_hit;
            if (setup)
                prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
        end
    end

    // Setup words; they are retained until cleared or rewritten.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_q  <= CFG_RST;
            pct_q  <= '0;
            band_q <= '0;
        end
        else
        begin
            if (wr_en && paddr == ADR_CFG)
                cfg_q <= pwdata[CFG_BITS-1:0];
            if (wr_en && paddr == ADR_BAND)
                band_q <= pwdata[W-1:0];
            if (cmd[CMD_CLEAR] && !cfg_q[CFG_CLRSC])
                pct_q <= '0;
            else if (wr_en && paddr == ADR_PCT)
                pct_q <= pwdata[9:0];
        end
    end

    // Entered limits: keyed in, captured from the platform, or cleared.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tg_q <= '0;
            lo_q <= '0;
            hi_q <= '0;
        end
        else if (cmd[CMD_CLEAR])
        begin
            tg_q <= '0;
            lo_q <= '0;
            hi_q <= '0;
        end
        else
        begin
            if (cmd[CMD_CAP_TG])
                tg_q <= net;
            else if (wr_en && paddr == ADR_TARGET)
                tg_q <= pwdata[W-1:0];
            if (cmd[CMD_CAP_LO])
                lo_q <= net;
            else if (wr_en && paddr == ADR_LOWER)
                lo_q <= pwdata[W-1:0];
            if (cmd[CMD_CAP_HI])
                hi_q <= net;
            else if (wr_en && paddr == ADR_UPPER)
                hi_q <= pwdata[W-1:0];
        end
    end

    // Reference key cycles the preset deviation in preset mode.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pidx_q <= '0;
        else if (cmd[CMD_CLEAR])
            pidx_q <= '0;
        else if (cmd[CMD_REF] && entry == CKW_E_PPRE)
            pidx_q <= (pidx_q == PCT_LAST) ? 4'h0 : pidx_q + 4'h1;
    end

    // Acceptance of the limits; a rejected entry keeps the old limits.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            init_q   <= 1'b0;
            err_q    <= 1'b0;
            act_tg_q <= '0;
            act_lo_q <= '0;
            act_hi_q <= '0;
        end
        else if (cmd[CMD_CLEAR])
            init_q <= 1'b0;
        else if (cmd[CMD_ACCEPT])
        begin
            err_q <= !acc_ok;
            if (acc_ok)
            begin
                init_q   <= 1'b1;
                act_tg_q <= tg_q;
                act_lo_q <= eff_lo;
                act_hi_q <= eff_hi;
            end
        end
    end

    // Tare: weighed, automatic, or manual entry merged by tare mode.
    always_comb
    begin
        if (cfg_q[CFG_TAREM])
            tare_nx = pwdata[W-1:0];
        else
            tare_nx = tare_q + pwdata[W-1:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tare_q <= '0;
        else if (cmd[CMD_CLEAR] && !cfg_q[CFG_CLRSC])
            tare_q <= '0;
        else if (cmd[CMD_TARE])
            tare_q <= gross_q;
        else if (wr_en && paddr == ADR_TARE)
            tare_q <= tare_nx;
        else if (cfg_q[CFG_ATARE] && tare_q == '0 && stable && gross_q >= minld)
            tare_q <= gross_q;
    end

    // Latest gross sample from the platform.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gross_q <= '0;
        else if (weight_valid)
            gross_q <= weight_in;
    end

    // Control lines, active low, idle high.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            light_n_q <= 1'b1;
            equal_n_q <= 1'b1;
            heavy_n_q <= 1'b1;
            set_n_q   <= 1'b1;
        end
        else
        begin
            light_n_q <= !(gate_en && below);
            equal_n_q <= !(gate_en && !below && !above);
            heavy_n_q <= !(gate_en && above);
            if (cfg_q[CFG_SET])
                set_n_q <= !init_q;
            else
                set_n_q <= !(gate_en && near);
        end
    end

    // Band indicators in relation-to-target display mode.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bli_q <= 1'b0;
            abi_q <= 1'b0;
        end
        else
        begin
            bli_q <= cfg_q[CFG_DISP] && init_q && below;
            abi_q <= cfg_q[CFG_DISP] && init_q && above;
        end
    end

    // Bar: leading-one position below lower, interval count above it.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            bar_q <= 8'h00;
        else if (below)
        begin
            bar_q <= 8'h00;
            for (int i = 0; i < W; i++)
                if (net[i])
                    bar_q <= 8'(i + 1);
        end
        else if (net - act_lo_q > W'(8'hff - BAR_LO_MARK))
            bar_q <= 8'hff;
        else
            bar_q <= BAR_LO_MARK + 8'(net - act_lo_q);
    end

    // Automatic print once per load above the minimum load.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            print_q <= 1'b0;
            armed_q <= 1'b1;
        end
        else
        begin
            print_q <= 1'b0;
            if (net < minld)
                armed_q <= 1'b1;
            else if (armed_q && init_q && stable)
            begin
                armed_q <= 1'b0;
                unique case (pmode)
                    CKW_P_OFF: print_q <= 1'b0;
                    CKW_P_ON:  print_q <= 1'b1;
                    CKW_P_IN:  print_q <= !below && !above;
                    CKW_P_OUT: print_q <= below || above;
                endcase
            end
        end
    end

    assign prdata               = prdata_q;
    assign pready               = pready_q;
    assign pslverr              = pslverr_q;
    assign lighter_n            = light_n_q;
    assign equal_n              = equal_n_q;
    assign heavier_n            = heavy_n_q;
    assign set_n                = set_n_q;
    assign below_band_indicator = bli_q;
    assign above_band_indicator = abi_q;
    assign print_req            = print_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_limit_reject: assert property (cmd[CMD_ACCEPT] && !cmd[CMD_CLEAR] && !acc_ok
        |=> err_q && act_lo_q == $past(act_lo_q))
        else $error("Bad limits were accepted.");
    a_ref_wrap: assert property (cmd[CMD_REF] && !cmd[CMD_CLEAR]
        && entry == CKW_E_PPRE && pidx_q == PCT_LAST |=> pidx_q == 4'h0)
        else $error("Preset step did not wrap.");
    a_gate_off: assert property (gate == CKW_G_OFF ##1 gate == CKW_G_OFF
        |-> light_n_q && equal_n_q && heavy_n_q)
        else $error("Lines active while gating is off.");
    a_idle_high: assert property (!init_q |=> light_n_q && equal_n_q && heavy_n_q)
        else $error("Line active before initialisation.");
    a_one_hot: assert property (gate_en |=> $onehot({~light_n_q, ~equal_n_q, ~heavy_n_q}))
        else $error("Not exactly one result line active.");
    a_tare_add: assert property (wr_en && paddr == ADR_TARE && !cfg_q[CFG_TAREM]
        && cmd == 7'h00 |=> tare_q == $past(tare_q) + $past(pwdata[W-1:0]))
        else $error("Manual tare not added.");
    a_tare_repl: assert property (cmd[CMD_TARE] && !cmd[CMD_CLEAR]
        |=> tare_q == $past(gross_q))
        else $error("Weighed tare did not replace.");
    a_clear_init: assert property (cmd[CMD_CLEAR] |=> !init_q ##1 !equal_n_q == 1'b0)
        else $error("Clear left the application live.");
    a_print_min: assert property (print_q |-> $past(net) >= $past(minld))
        else $error("Print below minimum load.");
endmodule

// >>> tb/ckw_ind.sv
`timescale 1ns/100ps
// Process controller that reads the four control lines and decodes a verdict.
module ckw_ind (
    input  wire logic       lighter_n,
    input  wire logic       equal_n,
    input  wire logic       heavier_n,
    input  wire logic       set_n,
    output logic [3:0]      lines,
    output logic [1:0]      active_cnt
);
    // A line is active when pulled low; an idle line rests high.
    assign lines      = {lighter_n, equal_n, heavier_n, set_n};
    // Counts verdict lines that are active at once.
    assign active_cnt = 2'(!lighter_n) + 2'(!equal_n) + 2'(!heavier_n);
endmodule

// >>> tb/tb_ckw_top.sv
`timescale 1ns/100ps
module tb_ckw_top;
    import ckw_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, weight_valid = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [23:0] weight_in = 24'h0;
    logic pready, pslverr, er, lighter_n, equal_n, heavier_n, set_n, lo_ind, hi_ind, print_req;
    logic [3:0] lines;
    logic [1:0] active_cnt;
    int num_errors = 0, samples_checked = 0;
    // Clock of 5 ns period.
    always #2.5 pclk = ~pclk;
    // Automatic print pulses seen so far; each pulse stands one cycle.
    int prints = 0;
    always @(posedge pclk)
        if (print_req === 1'b1)
            prints++;
    ckw_top #(.STAB_CNT(2)) ckw_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .weight_in(weight_in), .weight_valid(weight_valid), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .lighter_n(lighter_n), .equal_n(equal_n),
        .heavier_n(heavier_n), .set_n(set_n), .below_band_indicator(lo_ind),
        .above_band_indicator(hi_ind), .print_req(print_req));
    ckw_ind ckw_ind_i (.lighter_n(lighter_n), .equal_n(equal_n), .heavier_n(heavier_n),
        .set_n(set_n), .lines(lines), .active_cnt(active_cnt));
    // Compares one value and reports a mismatch at once.
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        samples_checked++;
        if (got !== ex)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, ex, got);
        end
    endtask
    // One APB transfer; waits for pready as long as it takes, the watchdog ends a hang.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
    endtask
    // Presents one weight sample, then lets the control lines settle.
    task automatic put_weight(input logic [23:0] v, input logic [3:0] ex);
        @(posedge pclk);
        weight_in <= v; weight_valid <= 1;
        @(posedge pclk);
        weight_valid <= 0;
        repeat (4) @(posedge pclk);
        chk("lines", {28'h0, ex}, {28'h0, lines});
        chk("verdict count", ex[3:1] == 3'b111 ? 0 : 1, {30'h0, active_cnt});
    endtask
    // Reset values, defaults and a refused access.
    task automatic t_reset;
        chk("idle lines", 32'hf, {28'h0, lines});
        apb(0, ADR_CFG, 0);
        chk("cfg default", 32'h28, rd);
        apb(0, 8'hfc, 0);
        chk("unmapped err", 1, {31'h0, er});
        $display("test reset done");
    endtask
    // Limits are refused with a zero lower limit, then accepted.
    task automatic t_limits;
        apb(1, ADR_CFG, 32'h04);
        apb(1, ADR_TARGET, 100); apb(1, ADR_LOWER, 0); apb(1, ADR_UPPER, 110);
        apb(1, ADR_CMD, 32'h40);
        apb(0, ADR_STATUS, 0);
        chk("reject", 32'h2, rd & 32'h3);
        put_weight(24'd80, 4'hf);
        apb(1, ADR_LOWER, 90); apb(1, ADR_CMD, 32'h40);
        apb(0, ADR_STATUS, 0);
        chk("accept", 32'h1, rd & 32'h3);
        $display("test limits done");
    endtask
    // Verdict lines with gating always on, then gated by range.
    task automatic t_lines;
        put_weight(24'd80, 4'h7);
        put_weight(24'd100, 4'ha);
        put_weight(24'd110, 4'ha);
        put_weight(24'd120, 4'hc);
        apb(0, ADR_NET, 0);
        chk("net", 32'd120, rd);
        apb(1, ADR_CFG, 32'h08);
        put_weight(24'd20, 4'hf);
        put_weight(24'd100, 4'ha);
        put_weight(24'd200, 4'hf);
        apb(1, ADR_CFG, 32'h00);
        put_weight(24'd100, 4'hf);
        $display("test lines done");
    endtask
    // Stability gating, one automatic print per load and the band indicators.
    task automatic t_more;
        apb(1, ADR_CFG, 32'h808c);
        put_weight(24'd100, 4'hf);
        put_weight(24'd100, 4'ha);
        chk("print count", 1, prints);
        put_weight(24'd80, 4'hf);
        chk("band ind", 32'h2, {30'h0, lo_ind, hi_ind});
        put_weight(24'd120, 4'hf);
        chk("band ind", 32'h1, {30'h0, lo_ind, hi_ind});
        $display("test more done");
    endtask
    // Manual and weighed tare, bar position, clear key and preset stepping.
    task automatic t_tare;
        apb(1, ADR_TARE, 5);
        apb(0, ADR_NET, 0);
        chk("net tared", 32'd115, rd);
        apb(0, ADR_BAR, 0);
        chk("bar", 32'h39, rd);
        apb(1, ADR_CMD, 32'h10);
        apb(0, ADR_NET, 0);
        chk("net weighed tare", 32'h0, rd);
        apb(1, ADR_CMD, 32'h20);
        apb(0, ADR_STATUS, 0);
        chk("cleared", 32'h0, rd & 32'h3);
        apb(0, ADR_TARE, 0);
        chk("tare cleared", 32'h0, rd);
        apb(1, ADR_CFG, 32'h20);
        repeat (8) apb(1, ADR_CMD, 32'h08);
        apb(0, ADR_PCT, 0);
        chk("preset idx", 32'h8, rd >> 10);
        apb(1, ADR_CMD, 32'h08);
        apb(0, ADR_PCT, 0);
        chk("preset wrap", 32'h0, rd >> 10);
        $display("test tare done");
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Main sequence after six reset cycles.
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        t_reset;
        t_limits;
        t_lines;
        t_more;
        t_tare;
        finish_test;
    end
    // Watchdog cuts a hang short.
    initial
    begin
        #50us;
        num_errors++;
        finish_test;
    end
endmodule
